// ### core/pfs_pb_lane.sv
// Port B single pin output selection
`timescale 1ns/1ps
module pfs_pb_lane (
  input wire logic [1:0] field,
  input wire logic forced,
  input wire logic dir,
  input wire logic gpio_out,
  input wire logic periph_out,
  input wire logic periph_oe,
  output logic out,
  output logic oe,
  output logic is_gpio
);
  // Mode override wins over the register field
  assign is_gpio = (field == pfs_pkg::PFS_SEL_GPIO) && !forced;
  // Direction counts only while general I/O is selected
  assign oe = is_gpio ? dir : periph_oe;
  assign out = is_gpio ? gpio_out : periph_out;
endmodule : pfs_pb_lane

// ### core/pfs_pkg.sv
// Constants shared by the port pin function select block
package pfs_pkg;
  localparam int PFS_PA_LINES = 12;
  localparam int PFS_PB_LINES = 10;
  localparam int PFS_SYNC_STAGES = 2;

  // Register indices on the plain register port
  localparam logic [2:0] PFS_IDX_PA_FIRST = 3'h0;
  localparam logic [2:0] PFS_IDX_PA_SECOND = 3'h1;
  localparam logic [2:0] PFS_IDX_PB_DIR = 3'h2;
  localparam logic [2:0] PFS_IDX_PB_HIGH = 3'h3;
  localparam logic [2:0] PFS_IDX_PB_LOW = 3'h4;

  // Writable bits; all others read as zero
  localparam logic [15:0] PFS_MASK_PA_FIRST = 16'h005F;
  localparam logic [15:0] PFS_MASK_PA_SECOND = 16'hFD75;
  localparam logic [15:0] PFS_MASK_PB_DIR = 16'h03FF;
  localparam logic [15:0] PFS_MASK_PB_HIGH = 16'h000F;
  localparam logic [15:0] PFS_MASK_PB_LOW = 16'hFFF5;

  // Values after power-on reset
  localparam logic [15:0] PFS_RST_PA_FIRST = 16'h0000;
  localparam logic [15:0] PFS_RST_PA_SECOND = 16'h0000;
  localparam logic [15:0] PFS_RST_PB_DIR = 16'h0000;
  localparam logic [15:0] PFS_RST_PB_HIGH = 16'h0000;
  localparam logic [15:0] PFS_RST_PB_LOW = 16'h0000;

  // Field positions, first port A register
  localparam int PFS_POS_L11 = 6;
  localparam int PFS_POS_L10 = 4;
  localparam int PFS_POS_L9 = 2;
  localparam int PFS_POS_L8 = 0;
  // Field positions, second port A register
  localparam int PFS_POS_L7 = 14;
  localparam int PFS_POS_L6 = 12;
  localparam int PFS_POS_L5 = 10;
  localparam int PFS_POS_L4 = 8;
  localparam int PFS_POS_L3 = 6;
  localparam int PFS_POS_L2 = 4;
  localparam int PFS_POS_L1 = 2;
  localparam int PFS_POS_L0 = 0;

  // Two-bit select codes
  localparam logic [1:0] PFS_SEL_GPIO = 2'h0;
  localparam logic [1:0] PFS_SEL_ALT1 = 2'h1;
  localparam logic [1:0] PFS_SEL_ALT2 = 2'h2;
  localparam logic [1:0] PFS_SEL_ALT3 = 2'h3;
endpackage : pfs_pkg

// ### core/pfs_sync.sv
// Two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps
module pfs_sync #(
  parameter int W = 1
) (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] sync;
  } pfs_sync_s;

  pfs_sync_s st_reg;
  pfs_sync_s st_next;

  always_comb begin
    st_next.meta = din;
    // First stage only feeds the second
    st_next.sync = st_reg.meta;
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign dout = st_reg.sync;
endmodule : pfs_sync

// ### core/pfs_top.sv
// Port A and port B pin function multiplexer with its select registers
// Operation
// - Line 11: bit 6 picks chip select 1; single chip keeps general I/O.
// - Line 10: bit 4 picks chip select 0; single chip keeps general I/O.
// - ROM invalid mode gives chip selects on lines 11, 10 even when cleared, except in single chip mode.
// - Line 9 field: I/O, timer clock D, interrupt 3, reserved.
// - Line 8 field: I/O, timer clock C, interrupt 2, reserved.
// - Line 7 field: I/O, timer clock B, chip select 3, reserved.
// - Line 6 field: I/O, timer clock A, chip select 2, reserved.
// - Line 5 field: I/O, serial clock 1, DMA request 1, interrupt 1.
// - Line 4 bit: I/O or serial 1 transmit output.
// - Line 3 bit: I/O or serial 1 receive input.
// - Line 2 field: I/O, serial clock 0, DMA request 0, interrupt 0.
// - Line 1 picks serial 0 transmit, line 0 serial 0 receive.
// - Reserved bits read zero; software writes them only as zero.
// - Port B direction holds ten bits; upper six read zero.
// - General I/O port B pin: direction 1 output, 0 input.
// - Direction bit ignored when another function is selected.
// - Only power-on reset clears port B direction to zero.
// - High port B register serves top two lines, low one the rest.
// - Operating mode may override port B bus and address selections.
// - Both port B function registers clear only on power-on reset.
// - Second port A register clears only on power-on reset.
//
// Our own choices: the register offsets and the strobed register port.
`timescale 1ns/1ps
module pfs_top (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic [2:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  input wire logic single_chip_mode,
  input wire logic rom_invalid_mode,
  input wire logic [11:0] porta_pin_in,
  output logic [11:0] porta_pin_out,
  output logic [11:0] porta_pin_oe,
  input wire logic [11:0] porta_gpio_out,
  input wire logic [11:0] porta_gpio_oe,
  input wire logic [3:0] chip_select_out_n,
  input wire logic serial_tx_ch0,
  input wire logic serial_tx_ch1,
  input wire logic [1:0] serial_clock_out,
  input wire logic [1:0] serial_clock_oe,
  output logic [3:0] timer_clock_in,
  output logic [3:0] ext_interrupt,
  output logic [1:0] serial_rx,
  output logic [1:0] serial_clock_in,
  output logic [1:0] dma_request,
  input wire logic [9:0] portb_pin_in,
  output logic [9:0] portb_pin_out,
  output logic [9:0] portb_pin_oe,
  output logic [9:0] portb_pin_sync,
  output logic [9:0] portb_gpio_sel,
  input wire logic [9:0] portb_gpio_out,
  input wire logic [9:0] portb_periph_out,
  input wire logic [9:0] portb_periph_oe,
  input wire logic [9:0] portb_mode_force
);
  typedef struct packed {
    logic [15:0] pa_first;
    logic [15:0] pa_second;
    logic [15:0] pb_dir;
    logic [15:0] pb_high;
    logic [15:0] pb_low;
    logic [15:0] rdata;
    logic [11:0] pa_out;
    logic [11:0] pa_oe;
    logic [9:0] pb_out;
    logic [9:0] pb_oe;
    logic [9:0] pb_gpio;
    logic [3:0] tclk;
    logic [3:0] irq;
    logic [1:0] rx;
    logic [1:0] sck;
    logic [1:0] dreq;
  } pfs_top_s;

  pfs_top_s st_reg;
  pfs_top_s st_next;

  logic [11:0] pa_sync;
  logic [9:0] pb_out_c;
  logic [9:0] pb_oe_c;
  logic [9:0] pb_gpio_c;
  logic [1:0] sel9;
  logic [1:0] sel8;
  logic [1:0] sel7;
  logic [1:0] sel6;
  logic [1:0] sel5;
  logic [1:0] sel2;
  logic cs1_on;
  logic cs0_on;

  pfs_sync #(.W(pfs_pkg::PFS_PA_LINES)) u_pa_sync (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .din(porta_pin_in),
    .dout(pa_sync)
  );

  pfs_sync #(.W(pfs_pkg::PFS_PB_LINES)) u_pb_sync (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .din(portb_pin_in),
    .dout(portb_pin_sync)
  );

  assign sel9 = st_reg.pa_first[pfs_pkg::PFS_POS_L9 +: 2];
  assign sel8 = st_reg.pa_first[pfs_pkg::PFS_POS_L8 +: 2];
  assign sel7 = st_reg.pa_second[pfs_pkg::PFS_POS_L7 +: 2];
  assign sel6 = st_reg.pa_second[pfs_pkg::PFS_POS_L6 +: 2];
  assign sel5 = st_reg.pa_second[pfs_pkg::PFS_POS_L5 +: 2];
  assign sel2 = st_reg.pa_second[pfs_pkg::PFS_POS_L2 +: 2];

  // Single chip mode has no external bus, so it beats ROM invalid mode
  assign cs1_on = !single_chip_mode && (st_reg.pa_first[pfs_pkg::PFS_POS_L11] || rom_invalid_mode);
  assign cs0_on = !single_chip_mode && (st_reg.pa_first[pfs_pkg::PFS_POS_L10] || rom_invalid_mode);

  // Top two lines use the high register, the rest the low one
  function automatic logic [1:0] pb_field(input int i, input logic [15:0] hi, input logic [15:0] lo);
    logic [1:0] f;
    f = 2'h0;
    if (i >= 8) begin
      f = hi[2*(i-8) +: 2];
    end else if (i >= 2) begin
      f = lo[2*i +: 2];
    end else begin
      f = {1'b0, lo[2*i]};
    end
    return f;
  endfunction : pb_field

  for (genvar g = 0; g < pfs_pkg::PFS_PB_LINES; g++) begin : g_pb
    pfs_pb_lane u_lane (
      .field(pb_field(g, st_reg.pb_high, st_reg.pb_low)),
      .forced(portb_mode_force[g]),
      .dir(st_reg.pb_dir[g]),
      .gpio_out(portb_gpio_out[g]),
      .periph_out(portb_periph_out[g]),
      .periph_oe(portb_periph_oe[g]),
      .out(pb_out_c[g]),
      .oe(pb_oe_c[g]),
      .is_gpio(pb_gpio_c[g])
    );
  end

  always_comb begin
    st_next = st_reg;
    st_next.rdata = 16'h0000;
    // Masking keeps reserved bits at zero whatever software writes
    if (reg_wr) begin
      unique case (reg_addr)
        pfs_pkg::PFS_IDX_PA_FIRST: st_next.pa_first = reg_wdata & pfs_pkg::PFS_MASK_PA_FIRST;
        pfs_pkg::PFS_IDX_PA_SECOND: st_next.pa_second = reg_wdata & pfs_pkg::PFS_MASK_PA_SECOND;
        pfs_pkg::PFS_IDX_PB_DIR: st_next.pb_dir = reg_wdata & pfs_pkg::PFS_MASK_PB_DIR;
        pfs_pkg::PFS_IDX_PB_HIGH: st_next.pb_high = reg_wdata & pfs_pkg::PFS_MASK_PB_HIGH;
        pfs_pkg::PFS_IDX_PB_LOW: st_next.pb_low = reg_wdata & pfs_pkg::PFS_MASK_PB_LOW;
        default: ;
      endcase
    end
    if (reg_rd) begin
      unique case (reg_addr)
        pfs_pkg::PFS_IDX_PA_FIRST: st_next.rdata = st_reg.pa_first;
        pfs_pkg::PFS_IDX_PA_SECOND: st_next.rdata = st_reg.pa_second;
        pfs_pkg::PFS_IDX_PB_DIR: st_next.rdata = st_reg.pb_dir;
        pfs_pkg::PFS_IDX_PB_HIGH: st_next.rdata = st_reg.pb_high;
        pfs_pkg::PFS_IDX_PB_LOW: st_next.rdata = st_reg.pb_low;
        default: st_next.rdata = 16'h0000;
      endcase
    end

    // General I/O unless a line is claimed below
    st_next.pa_out = porta_gpio_out;
    st_next.pa_oe = porta_gpio_oe;
    st_next.tclk = 4'h0;
    st_next.irq = 4'h0;
    st_next.rx = 2'h0;
    st_next.sck = 2'h0;
    st_next.dreq = 2'h0;

    if (cs1_on) begin
      st_next.pa_out[11] = chip_select_out_n[1];
      st_next.pa_oe[11] = 1'b1;
    end
    if (cs0_on) begin
      st_next.pa_out[10] = chip_select_out_n[0];
      st_next.pa_oe[10] = 1'b1;
    end
    // Reserved codes fall back to general I/O
    if (sel9 == pfs_pkg::PFS_SEL_ALT1) begin
      st_next.tclk[3] = pa_sync[9];
      st_next.pa_oe[9] = 1'b0;
    end else if (sel9 == pfs_pkg::PFS_SEL_ALT2) begin
      st_next.irq[3] = pa_sync[9];
      st_next.pa_oe[9] = 1'b0;
    end
    if (sel8 == pfs_pkg::PFS_SEL_ALT1) begin
      st_next.tclk[2] = pa_sync[8];
      st_next.pa_oe[8] = 1'b0;
    end else if (sel8 == pfs_pkg::PFS_SEL_ALT2) begin
      st_next.irq[2] = pa_sync[8];
      st_next.pa_oe[8] = 1'b0;
    end
    if (sel7 == pfs_pkg::PFS_SEL_ALT1) begin
      st_next.tclk[1] = pa_sync[7];
      st_next.pa_oe[7] = 1'b0;
    end else if (sel7 == pfs_pkg::PFS_SEL_ALT2 && !single_chip_mode) begin
      st_next.pa_out[7] = chip_select_out_n[3];
      st_next.pa_oe[7] = 1'b1;
    end
    if (sel6 == pfs_pkg::PFS_SEL_ALT1) begin
      st_next.tclk[0] = pa_sync[6];
      st_next.pa_oe[6] = 1'b0;
    end else if (sel6 == pfs_pkg::PFS_SEL_ALT2 && !single_chip_mode) begin
      st_next.pa_out[6] = chip_select_out_n[2];
      st_next.pa_oe[6] = 1'b1;
    end
    if (sel5 == pfs_pkg::PFS_SEL_ALT1) begin
      st_next.sck[1] = pa_sync[5];
      st_next.pa_out[5] = serial_clock_out[1];
      st_next.pa_oe[5] = serial_clock_oe[1];
    end else if (sel5 == pfs_pkg::PFS_SEL_ALT2 && !single_chip_mode) begin
      st_next.dreq[1] = pa_sync[5];
      st_next.pa_oe[5] = 1'b0;
    end else if (sel5 == pfs_pkg::PFS_SEL_ALT3) begin
      st_next.irq[1] = pa_sync[5];
      st_next.pa_oe[5] = 1'b0;
    end
    if (st_reg.pa_second[pfs_pkg::PFS_POS_L4]) begin
      st_next.pa_out[4] = serial_tx_ch1;
      st_next.pa_oe[4] = 1'b1;
    end
    if (st_reg.pa_second[pfs_pkg::PFS_POS_L3]) begin
      st_next.rx[1] = pa_sync[3];
      st_next.pa_oe[3] = 1'b0;
    end
    if (sel2 == pfs_pkg::PFS_SEL_ALT1) begin
      st_next.sck[0] = pa_sync[2];
      st_next.pa_out[2] = serial_clock_out[0];
      st_next.pa_oe[2] = serial_clock_oe[0];
    end else if (sel2 == pfs_pkg::PFS_SEL_ALT2 && !single_chip_mode) begin
      st_next.dreq[0] = pa_sync[2];
      st_next.pa_oe[2] = 1'b0;
    end else if (sel2 == pfs_pkg::PFS_SEL_ALT3) begin
      st_next.irq[0] = pa_sync[2];
      st_next.pa_oe[2] = 1'b0;
    end
    if (st_reg.pa_second[pfs_pkg::PFS_POS_L1]) begin
      st_next.pa_out[1] = serial_tx_ch0;
      st_next.pa_oe[1] = 1'b1;
    end
    if (st_reg.pa_second[pfs_pkg::PFS_POS_L0]) begin
      st_next.rx[0] = pa_sync[0];
      st_next.pa_oe[0] = 1'b0;
    end

    st_next.pb_out = pb_out_c;
    st_next.pb_oe = pb_oe_c;
    st_next.pb_gpio = pb_gpio_c;
  end

  // rst_b is the power-on reset; other resets never reach these registers
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      st_reg <= '0;
      st_reg.pa_first <= pfs_pkg::PFS_RST_PA_FIRST;
      st_reg.pa_second <= pfs_pkg::PFS_RST_PA_SECOND;
      st_reg.pb_dir <= pfs_pkg::PFS_RST_PB_DIR;
      st_reg.pb_high <= pfs_pkg::PFS_RST_PB_HIGH;
      st_reg.pb_low <= pfs_pkg::PFS_RST_PB_LOW;
    end else begin
      st_reg <= st_next;
    end
  end

  assign reg_rdata = st_reg.rdata;
  assign porta_pin_out = st_reg.pa_out;
  assign porta_pin_oe = st_reg.pa_oe;
  assign portb_pin_out = st_reg.pb_out;
  assign portb_pin_oe = st_reg.pb_oe;
  assign portb_gpio_sel = st_reg.pb_gpio;
  assign timer_clock_in = st_reg.tclk;
  assign ext_interrupt = st_reg.irq;
  assign serial_rx = st_reg.rx;
  assign serial_clock_in = st_reg.sck;
  assign dma_request = st_reg.dreq;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);

  a_l11_chip_sel: assert property (cs1_on |=> porta_pin_oe[11]
    && porta_pin_out[11] == $past(chip_select_out_n[1]))
    else $error("line 11 not driving chip select 1");
  a_single_chip_gpio: assert property (single_chip_mode
    |=> porta_pin_oe[10] == $past(porta_gpio_oe[10]))
    else $error("line 10 left general I/O in single chip mode");
  a_rom_inv_cs: assert property (rom_invalid_mode && !single_chip_mode
    && !st_reg.pa_first[pfs_pkg::PFS_POS_L10]
    |=> porta_pin_oe[10] && porta_pin_out[10] == $past(chip_select_out_n[0]))
    else $error("ROM invalid mode lost chip select 0");
  a_l9_irq_route: assert property (sel9 == 2'h2
    |=> ext_interrupt[3] == $past(pa_sync[9]) && !porta_pin_oe[9])
    else $error("line 9 interrupt route wrong");
  a_l8_timer_route: assert property (sel8 == 2'h1 ##1 sel8 == 2'h1
    |=> timer_clock_in[2] == $past(pa_sync[8]))
    else $error("line 8 timer clock route wrong");
  a_l7_cs3_drive: assert property (sel7 == 2'h2 && !single_chip_mode
    |=> porta_pin_oe[7] && porta_pin_out[7] == $past(chip_select_out_n[3]))
    else $error("line 7 chip select 3 wrong");
  a_l6_cs2_drive: assert property (sel6 == 2'h2 && !single_chip_mode
    |=> porta_pin_oe[6] && porta_pin_out[6] == $past(chip_select_out_n[2]))
    else $error("line 6 chip select 2 wrong");
  a_l5_sck_out: assert property (sel5 == 2'h1
    |=> porta_pin_oe[5] == $past(serial_clock_oe[1]) && serial_clock_in[1] == $past(pa_sync[5]))
    else $error("line 5 serial clock route wrong");
  a_l4_tx_out: assert property (st_reg.pa_second[pfs_pkg::PFS_POS_L4]
    |=> porta_pin_oe[4] && porta_pin_out[4] == $past(serial_tx_ch1))
    else $error("line 4 transmit route wrong");
  a_l3_rx_route: assert property (st_reg.pa_second[pfs_pkg::PFS_POS_L3]
    |=> serial_rx[1] == $past(pa_sync[3]) && !porta_pin_oe[3])
    else $error("line 3 receive route wrong");
  a_dreq_single_chip: assert property (single_chip_mode |=> dma_request == 2'h0)
    else $error("DMA request routed in single chip mode");
  a_l0_rx_route: assert property (st_reg.pa_second[pfs_pkg::PFS_POS_L0]
    |=> serial_rx[0] == $past(pa_sync[0]) && !porta_pin_oe[0])
    else $error("line 0 receive route wrong");
  a_reserved_read: assert property (reg_rd && reg_addr == 3'h1
    |=> (reg_rdata & ~16'hFD75) == 16'h0000)
    else $error("reserved bits read nonzero");
  a_dir_upper_zero: assert property (reg_wr && reg_addr == 3'h2 ##1 reg_rd && reg_addr == 3'h2
    |=> reg_rdata == ($past(reg_wdata, 2) & 16'h03FF))
    else $error("direction readback wrong");
  a_dir_drives_oe: assert property (pb_gpio_c[0] && !reg_wr
    |=> portb_pin_oe[0] == $past(st_reg.pb_dir[0]))
    else $error("port B direction not applied");
  a_periph_owns_pin: assert property (!pb_gpio_c[3]
    |=> portb_pin_oe[3] == $past(portb_periph_oe[3]) && portb_pin_out[3] == $past(portb_periph_out[3]))
    else $error("peripheral pin not owned by peripheral");
  a_high_field_line9: assert property (st_reg.pb_high[3:2] != 2'h0 |=> !portb_gpio_sel[9])
    else $error("high function register ignored for line 9");
  a_force_override: assert property (portb_mode_force[9] |=> !portb_gpio_sel[9])
    else $error("mode override ignored");
  a_rdata_one_cycle: assert property (!reg_rd |=> reg_rdata == 16'h0000)
    else $error("read data outside read answer cycle");
  // Reset is the event checked here, so the default disable must not mask it
  a_por_clear: assert property (@(posedge clk_sys) disable iff (1'b0) !rst_b
    |=> st_reg.pb_dir == 16'h0000 && st_reg.pb_high == 16'h0000
    && st_reg.pb_low == 16'h0000 && st_reg.pa_second == 16'h0000)
    else $error("power-on reset did not clear registers");

  c_rom_invalid_cs: cover property (rom_invalid_mode && !single_chip_mode ##1 porta_pin_oe[11]);
  c_serial_clock: cover property (sel2 == 2'h1 ##1 porta_pin_oe[2]);
  c_portb_periph: cover property (!pb_gpio_c[5] ##1 portb_pin_oe[5]);
  c_dir_write: cover property (reg_wr && reg_addr == 3'h2 ##2 portb_pin_oe[0]);
  c_dreq_route: cover property (sel5 == 2'h2 && !single_chip_mode ##1 dma_request[1]);
endmodule : pfs_top

// ### tb/pfs_top_tb_top.sv
// Self-checking testbench for the port pin function select block
`timescale 1ns/1ps
`define CHK(what, exp, got) begin checked++; if ((got) !== (exp)) begin fail_count++; \
  $display("[ERR] %s expected %h seen %h", what, exp, got); end end
module pfs_top_tb_top;
  logic clk_sys = 1'b0;
  logic rst_b = 1'b0;
  logic [2:0] reg_addr = 3'h0;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [15:0] reg_rdata;
  logic single_chip_mode = 1'b0;
  logic rom_invalid_mode = 1'b0;
  logic [11:0] porta_pin_in = 12'h000;
  logic [11:0] porta_pin_out;
  logic [11:0] porta_pin_oe;
  logic [11:0] porta_gpio_out = 12'h000;
  logic [11:0] porta_gpio_oe = 12'h000;
  logic [3:0] chip_select_out_n = 4'h0;
  logic serial_tx_ch0 = 1'b0;
  logic serial_tx_ch1 = 1'b0;
  logic [1:0] serial_clock_out = 2'h0;
  logic [1:0] serial_clock_oe = 2'h0;
  logic [3:0] timer_clock_in;
  logic [3:0] ext_interrupt;
  logic [1:0] serial_rx;
  logic [1:0] serial_clock_in;
  logic [1:0] dma_request;
  logic [9:0] portb_pin_in = 10'h000;
  logic [9:0] portb_pin_out;
  logic [9:0] portb_pin_oe;
  logic [9:0] portb_pin_sync;
  logic [9:0] portb_gpio_sel;
  logic [9:0] portb_gpio_out = 10'h000;
  logic [9:0] portb_periph_out = 10'h000;
  logic [9:0] portb_periph_oe = 10'h000;
  logic [9:0] portb_mode_force = 10'h000;
  int fail_count = 0;
  int checked = 0;

  pfs_top u_dut (
    .clk_sys(clk_sys), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .single_chip_mode(single_chip_mode),
    .rom_invalid_mode(rom_invalid_mode), .porta_pin_in(porta_pin_in), .porta_pin_out(porta_pin_out),
    .porta_pin_oe(porta_pin_oe), .porta_gpio_out(porta_gpio_out), .porta_gpio_oe(porta_gpio_oe),
    .chip_select_out_n(chip_select_out_n), .serial_tx_ch0(serial_tx_ch0), .serial_tx_ch1(serial_tx_ch1),
    .serial_clock_out(serial_clock_out), .serial_clock_oe(serial_clock_oe), .timer_clock_in(timer_clock_in),
    .ext_interrupt(ext_interrupt), .serial_rx(serial_rx), .serial_clock_in(serial_clock_in),
    .dma_request(dma_request), .portb_pin_in(portb_pin_in), .portb_pin_out(portb_pin_out),
    .portb_pin_oe(portb_pin_oe), .portb_pin_sync(portb_pin_sync), .portb_gpio_sel(portb_gpio_sel),
    .portb_gpio_out(portb_gpio_out), .portb_periph_out(portb_periph_out),
    .portb_periph_oe(portb_periph_oe), .portb_mode_force(portb_mode_force)
  );

  always #2 clk_sys = ~clk_sys;

  task automatic reg_write(input logic [2:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask : reg_write

  // Read data stand only in the cycle after the strobe
  task automatic reg_read(input logic [2:0] a, output logic [15:0] d);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask : reg_read

  // Covers the three-cycle pin-to-peripheral path with margin
  task automatic settle;
    repeat (4) @(posedge clk_sys);
    #1;
  endtask : settle

  task automatic test_registers;
    logic [15:0] d;
    logic [15:0] masks [5] = '{pfs_pkg::PFS_MASK_PA_FIRST, pfs_pkg::PFS_MASK_PA_SECOND,
      pfs_pkg::PFS_MASK_PB_DIR, pfs_pkg::PFS_MASK_PB_HIGH, pfs_pkg::PFS_MASK_PB_LOW};
    for (int i = 0; i < 5; i++) begin
      reg_read(3'(i), d);
      `CHK("reset value", 16'h0000, d)
      reg_write(3'(i), 16'hFFFF);
      reg_read(3'(i), d);
      `CHK("writable bits", masks[i], d)
    end
    reg_write(3'h5, 16'hFFFF);
    reg_read(3'h5, d);
    `CHK("unmapped read", 16'h0000, d)
    // Write then read with no gap must see the new direction value
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= pfs_pkg::PFS_IDX_PB_DIR;
    reg_wdata <= 16'hFC5A;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
    `CHK("back to back read", 16'hFC5A & pfs_pkg::PFS_MASK_PB_DIR, d)
    // Second power-on reset in mid-run must clear everything again
    @(posedge clk_sys);
    rst_b <= 1'b0;
    repeat (3) @(posedge clk_sys);
    rst_b <= 1'b1;
    for (int i = 0; i < 5; i++) begin
      reg_read(3'(i), d);
      `CHK("value after reset", 16'h0000, d)
    end
    $display("test registers done");
  endtask : test_registers

  task automatic test_porta_inputs;
    reg_write(pfs_pkg::PFS_IDX_PA_FIRST, 16'h0006);
    reg_write(pfs_pkg::PFS_IDX_PA_SECOND, 16'h5C61);
    @(posedge clk_sys);
    porta_pin_in <= 12'hFFF;
    porta_gpio_oe <= 12'hFFF;
    settle;
    `CHK("timer inputs", 4'hB, timer_clock_in)
    `CHK("interrupt inputs", 4'h6, ext_interrupt)
    `CHK("serial receive", 2'h3, serial_rx)
    `CHK("serial clock in", 2'h0, serial_clock_in)
    `CHK("dma requests", 2'h1, dma_request)
    `CHK("port A enables", 12'hC12, porta_pin_oe)
    @(posedge clk_sys);
    porta_pin_in <= 12'h000;
    settle;
    `CHK("timer inputs low", 4'h0, timer_clock_in)
    `CHK("interrupt inputs low", 4'h0, ext_interrupt)
    `CHK("dma requests low", 2'h0, dma_request)
    $display("test porta_inputs done");
  endtask : test_porta_inputs

  task automatic test_porta_outputs;
    reg_write(pfs_pkg::PFS_IDX_PA_FIRST, 16'h0059);
    reg_write(pfs_pkg::PFS_IDX_PA_SECOND, 16'h0514);
    @(posedge clk_sys);
    porta_pin_in <= 12'hFFF;
    porta_gpio_oe <= 12'h000;
    chip_select_out_n <= 4'hA;
    serial_clock_out <= 2'h2;
    serial_clock_oe <= 2'h3;
    serial_tx_ch0 <= 1'b1;
    settle;
    `CHK("port A enables", 12'hC36, porta_pin_oe)
    `CHK("port A drive", 12'h822, porta_pin_out & porta_pin_oe)
    `CHK("timer inputs", 4'h4, timer_clock_in)
    `CHK("interrupt inputs", 4'h8, ext_interrupt)
    `CHK("serial clock in", 2'h3, serial_clock_in)
    `CHK("serial receive", 2'h0, serial_rx)
    $display("test porta_outputs done");
  endtask : test_porta_outputs

  task automatic test_modes;
    logic [1:0] md [3] = '{2'h0, 2'h1, 2'h3};
    logic [11:0] eoe [3] = '{12'hFDB, 12'hFDB, 12'hFFF};
    logic [11:0] eout [3] = '{12'hA4A, 12'h64A, 12'hAAA};
    logic [1:0] edma [3] = '{2'h3, 2'h3, 2'h0};
    // Reserved codes on lines 9 and 8 must fall back to general I/O
    reg_write(pfs_pkg::PFS_IDX_PA_FIRST, 16'h000F);
    reg_write(pfs_pkg::PFS_IDX_PA_SECOND, 16'hA820);
    for (int i = 0; i < 3; i++) begin
      @(posedge clk_sys);
      single_chip_mode <= md[i][1];
      rom_invalid_mode <= md[i][0];
      porta_gpio_out <= 12'hAAA;
      porta_gpio_oe <= 12'hFFF;
      chip_select_out_n <= 4'h5;
      settle;
      `CHK("mode enables", eoe[i], porta_pin_oe)
      `CHK("mode drive", eout[i], porta_pin_out & porta_pin_oe)
      `CHK("mode dma", edma[i], dma_request)
    end
    $display("test modes done");
  endtask : test_modes

  task automatic test_portb;
    reg_write(pfs_pkg::PFS_IDX_PB_DIR, 16'h0155);
    @(posedge clk_sys);
    portb_gpio_out <= 10'h3FF;
    portb_periph_oe <= 10'h3FF;
    portb_pin_in <= 10'h2A5;
    settle;
    `CHK("gpio select", 10'h3FF, portb_gpio_sel)
    `CHK("direction enables", 10'h155, portb_pin_oe)
    `CHK("gpio drive", 10'h155, portb_pin_out & portb_pin_oe)
    `CHK("pin sync", 10'h2A5, portb_pin_sync)
    reg_write(pfs_pkg::PFS_IDX_PB_HIGH, 16'h0004);
    reg_write(pfs_pkg::PFS_IDX_PB_LOW, 16'h0001);
    @(posedge clk_sys);
    portb_mode_force <= 10'h010;
    settle;
    `CHK("gpio select mixed", 10'h1EE, portb_gpio_sel)
    `CHK("mixed enables", 10'h355, portb_pin_oe)
    `CHK("mixed drive", 10'h144, portb_pin_out & portb_pin_oe)
    $display("test portb done");
  endtask : test_portb

  task automatic test_done;
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : test_done

  initial begin
    repeat (10) @(posedge clk_sys);
    rst_b <= 1'b1;
    test_registers;
    test_porta_inputs;
    test_porta_outputs;
    test_modes;
    test_portb;
    test_done;
  end

  // Whole sequence needs about 120 cycles; allow some forty times that
  initial begin
    #20000;
    fail_count++;
    test_done;
  end
endmodule : pfs_top_tb_top
